// File: logic/tss_pkg.sv
// Purpose: shared constants and types for the pcm time/space switch
// Assumes: 8 lines x 32 channels x 8 bits, 2 master clocks per bit
// Notes:   all widths fixed; no bus registers reachable by software

// ************************************************************
// package
// ************************************************************
package tss_pkg;

  // ************************************************************
  // frame geometry
  // ************************************************************
  localparam int LINES  = 8;
  localparam int LINE_W = 3;
  localparam int SLOT_W = 5;
  localparam int BIT_W  = 3;
  localparam int ADDR_W = 8;
  localparam int WORD_W = 8;
  localparam int CM_W   = 9;
  localparam int ARG_W  = 5;
  localparam int MEM_DEPTH = 256;

  localparam logic [BIT_W-1:0]  LAST_BIT   = 3'h7;
  localparam logic [SLOT_W-1:0] FIRST_SLOT = 5'h00;
  localparam logic [BIT_W-1:0]  FIRST_BIT  = 3'h0;

  // connection memory word: top bit selects message
  localparam int              CM_MSG_BIT = 8;
  localparam logic [CM_W-1:0] CM_CLEAR   = 9'h000;
  localparam logic [CM_W-1:0] CM_IDLE    = 9'h1ff;
  localparam logic [CM_W-1:0] CM_LAST    = 9'h100;
  localparam logic            CM_POINTER = 1'b0;
  localparam logic            CM_MESSAGE = 1'b1;

  // ************************************************************
  // command queue and opcodes
  // ************************************************************
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W     = 7;       // {match, cmd/data, 5 bits}

  localparam logic [2:0] OP_CONNECT = 3'h1;
  localparam logic [2:0] OP_DISCON  = 3'h2;
  localparam logic [2:0] OP_MESSAGE = 3'h3;
  localparam logic [2:0] OP_READ_CM = 3'h4;
  localparam logic [2:0] OP_READ_DM = 3'h5;
  localparam logic [2:0] ARGS_FOUR  = 3'h4;
  localparam logic [2:0] ARGS_TWO   = 3'h2;
  localparam logic [1:0] STATUS_PAD = 2'h0;

  // ************************************************************
  // pin sample group, passed through two flip-flops
  // ************************************************************
  typedef struct packed {
    logic              mclk;
    logic              fsync;
    logic              rst_n;
    logic [LINES-1:0]  ser;
    logic [WORD_W-1:0] data;
    logic [1:0]        sel_n;
    logic [1:0]        match;
    logic [1:0]        strap;
    logic              wr_n;
    logic              rd_n;
    logic              cd;
  } tss_pins_s;

endpackage : tss_pkg

// File: logic/tss_fifo.sv
// Purpose: command byte queue between bus capture and executor
// Assumes: single clock, valid/ready on both sides
// Notes:   full and empty come straight from the pointers

`timescale 1ns/100ps

// ************************************************************
// fifo
// ************************************************************
module tss_fifo #(
  parameter int WIDTH = 7,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW:0] wp;
    logic [PW:0] rp;
  } tss_fifo_s;

  tss_fifo_s        r_reg;
  tss_fifo_s        r_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             full;
  logic             empty;
  logic             do_push;
  logic             do_pop;

  // extra pointer bit tells full from empty
  assign empty   = (r_reg.wp == r_reg.rp);
  assign full    = (r_reg.wp[PW-1:0] == r_reg.rp[PW-1:0]) &&
                   (r_reg.wp[PW] != r_reg.rp[PW]);
  assign do_push = in_valid_i & ~full;
  assign do_pop  = out_ready_i & ~empty;

  assign in_ready_o  = ~full;
  assign out_valid_o = ~empty;
  assign out_data_o  = mem[r_reg.rp[PW-1:0]];

  // pointer advance
  always_comb begin
    r_next = r_reg;
    if (do_push) begin
      r_next.wp = r_reg.wp + (PW+1)'(1);
    end
    if (do_pop) begin
      r_next.rp = r_reg.rp + (PW+1)'(1);
    end
  end

  // pointer registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[r_reg.wp[PW-1:0]] <= in_data_i;
    end
  end

endmodule : tss_fifo

// File: logic/tss_switch.sv
// Purpose: 8 x 32 channel pcm time/space switch with processor port
// Assumes: master clock, frame start and all bus pins are asynchronous
// Notes:   every pin passes two flip-flops; one-clock edge detection

`timescale 1ns/100ps

// ************************************************************
// switch top
// ************************************************************
module tss_switch (
  // system clock and reset
  input  wire logic       SYS_CLK_I,
  input  wire logic       RESET_I,
  // serial timing pins
  input  wire logic       MCLK_I,
  input  wire logic       FRAME_SYNC_I,
  input  wire logic       INIT_N_I,
  // serial pcm lines
  input  wire logic [7:0] SERIAL_IN_LINE_I,
  output logic      [7:0] SERIAL_OUT_LINE_O,
  output logic      [7:0] SERIAL_OUT_LINE_OE_O,
  // processor data bus
  input  wire logic [7:0] DATA_I,
  output logic      [7:0] DATA_O,
  output logic            DATA_OE_O,
  // processor control
  input  wire logic       SELECT_N_FIRST_I,
  input  wire logic       SELECT_N_SECOND_I,
  input  wire logic       CASCADE_MATCH_A_I,
  input  wire logic       CASCADE_MATCH_B_I,
  input  wire logic       CASCADE_STRAP_A_I,
  input  wire logic       CASCADE_STRAP_B_I,
  input  wire logic       WR_N_I,
  input  wire logic       RD_N_I,
  input  wire logic       CMD_DATA_I,
  output logic            READY_FLAG_OUT_O
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    tss_pkg::tss_pins_s                                s1;
    tss_pkg::tss_pins_s                                s2;
    logic                                              prev_mclk;
    logic                                              prev_fsync;
    logic                                              prev_wr_n;
    logic                                              prev_rd_n;
    logic                                              half;
    logic [tss_pkg::BIT_W-1:0]                         bitc;
    logic [tss_pkg::SLOT_W-1:0]                        slot;
    logic [tss_pkg::LINES-1:0][tss_pkg::WORD_W-1:0]    ish;
    logic [tss_pkg::LINES-1:0][tss_pkg::WORD_W-1:0]    osh;
    logic [tss_pkg::LINES-1:0]                         oe;
    logic [tss_pkg::LINES-1:0]                         lvl;
    logic                                              init;
    logic [tss_pkg::CM_W-1:0]                          clr;
    logic [3:0][tss_pkg::ARG_W-1:0]                    stk;
    logic [2:0]                                        cnt;
    logic                                              err;
    logic [2:0]                                        op;
    logic [tss_pkg::WORD_W-1:0]                        mrd;
    logic [tss_pkg::WORD_W-1:0]                        dout;
    logic                                              doe;
    logic                                              rdy;
  } tss_state_s;

  tss_state_s                  r_reg;
  tss_state_s                  r_next;
  tss_pkg::tss_pins_s          pins;

  // memories
  logic [tss_pkg::WORD_W-1:0]  dm_mem [tss_pkg::MEM_DEPTH];
  logic [tss_pkg::CM_W-1:0]    cm_mem [tss_pkg::MEM_DEPTH];
  logic                        dm_we;
  logic                        cm_we;
  logic [tss_pkg::ADDR_W-1:0]  cm_waddr;
  logic [tss_pkg::CM_W-1:0]    cm_wdata;

  // output byte fetch for the coming slot
  logic [tss_pkg::SLOT_W-1:0]  ld_slot;
  logic [tss_pkg::CM_W-1:0]    cm_ld [tss_pkg::LINES];
  logic [tss_pkg::WORD_W-1:0]  obyte [tss_pkg::LINES];

  // edges and decodes
  logic                        mclk_rise;
  logic                        fs_rise;
  logic                        wr_rise;
  logic                        rd_fall;
  logic                        sel;
  logic                        matched;
  logic                        both_low;

  // command queue
  logic                        push;
  logic                        pop;
  logic                        q_in_ready;
  logic                        q_valid;
  logic [tss_pkg::FIFO_W-1:0]  q_data;
  logic [tss_pkg::FIFO_W-1:0]  q_wdata;
  logic [tss_pkg::ADDR_W-1:0]  arg_addr;

  // join a line and a slot into a memory address
  function automatic logic [tss_pkg::ADDR_W-1:0] mem_addr(
    input logic [tss_pkg::ARG_W-1:0] line,
    input logic [tss_pkg::ARG_W-1:0] chan
  );
    mem_addr = {line[tss_pkg::LINE_W-1:0], chan[tss_pkg::SLOT_W-1:0]};
  endfunction : mem_addr

  // ************************************************************
  // pin gathering and edge decode
  // ************************************************************
  assign pins = '{mclk:  MCLK_I,
                  fsync: FRAME_SYNC_I,
                  rst_n: INIT_N_I,
                  ser:   SERIAL_IN_LINE_I,
                  data:  DATA_I,
                  sel_n: {SELECT_N_SECOND_I, SELECT_N_FIRST_I},
                  match: {CASCADE_MATCH_B_I, CASCADE_MATCH_A_I},
                  strap: {CASCADE_STRAP_B_I, CASCADE_STRAP_A_I},
                  wr_n:  WR_N_I,
                  rd_n:  RD_N_I,
                  cd:    CMD_DATA_I};

  // edges look at the second stage only, never the first
  assign mclk_rise = r_reg.s2.mclk & ~r_reg.prev_mclk;
  assign fs_rise   = r_reg.s2.fsync & ~r_reg.prev_fsync;
  assign wr_rise   = r_reg.s2.wr_n & ~r_reg.prev_wr_n;
  assign rd_fall   = ~r_reg.s2.rd_n & r_reg.prev_rd_n;
  assign sel       = ~r_reg.s2.sel_n[0] & ~r_reg.s2.sel_n[1];
  assign matched   = (r_reg.s2.match == r_reg.s2.strap);
  assign both_low  = ~r_reg.s2.wr_n & ~r_reg.s2.rd_n;

  // opcode or data byte, top three bits dropped; match kept per byte
  assign q_wdata = {matched, r_reg.s2.cd,
                    r_reg.s2.data[tss_pkg::ARG_W-1:0]};
  assign push    = wr_rise & sel & r_reg.s2.rd_n;
  // executor stalls during init and while both strobes are low
  assign pop     = q_valid & ~r_reg.init & ~both_low;

  // address built from the two newest argument bytes
  assign arg_addr = mem_addr(r_reg.stk[1], r_reg.stk[0]);

  // ************************************************************
  // command queue
  // ************************************************************
  tss_fifo #(
    .WIDTH (tss_pkg::FIFO_W),
    .DEPTH (tss_pkg::FIFO_DEPTH)
  ) u_queue (
    .clk_i       (SYS_CLK_I),
    .rst_i       (RESET_I),
    .in_valid_i  (push),
    .in_ready_o  (q_in_ready),
    .in_data_i   (q_wdata),
    .out_valid_o (q_valid),
    .out_ready_i (pop),
    .out_data_o  (q_data)
  );

  // ************************************************************
  // output byte fetch
  // ************************************************************
  assign ld_slot = fs_rise ? tss_pkg::FIRST_SLOT
                           : r_reg.slot + tss_pkg::SLOT_W'(1);

  // one connection word per line; pointer or message byte
  always_comb begin
    for (int l = 0; l < tss_pkg::LINES; l++) begin
      cm_ld[l] = cm_mem[{tss_pkg::LINE_W'(l), ld_slot}];
      obyte[l] = cm_ld[l][tss_pkg::CM_MSG_BIT]
                 ? cm_ld[l][tss_pkg::WORD_W-1:0]
                 : dm_mem[cm_ld[l][tss_pkg::ADDR_W-1:0]];
    end
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    r_next   = r_reg;
    dm_we    = 1'b0;
    cm_we    = 1'b0;
    cm_waddr = arg_addr;
    cm_wdata = tss_pkg::CM_IDLE;

    // two-stage pin synchroniser and edge history
    r_next.s1         = pins;
    r_next.s2         = r_reg.s1;
    r_next.prev_mclk  = r_reg.s2.mclk;
    r_next.prev_fsync = r_reg.s2.fsync;
    r_next.prev_wr_n  = r_reg.s2.wr_n;
    r_next.prev_rd_n  = r_reg.s2.rd_n;

    // frame timing: frame start wins over a clock edge
    if (fs_rise) begin
      r_next.half = 1'b0;
      r_next.bitc = tss_pkg::FIRST_BIT;
      r_next.slot = tss_pkg::FIRST_SLOT;
      r_next.init = ~r_reg.s2.rst_n;
      r_next.clr  = tss_pkg::CM_CLEAR;
      for (int l = 0; l < tss_pkg::LINES; l++) begin
        r_next.osh[l] = obyte[l];
      end
    end else if (mclk_rise) begin
      r_next.half = ~r_reg.half;
      if (!r_reg.half) begin
        // mid cell: sample inputs, msb arrives first
        for (int l = 0; l < tss_pkg::LINES; l++) begin
          r_next.ish[l] = {r_reg.ish[l][tss_pkg::WORD_W-2:0],
                           r_reg.s2.ser[l]};
        end
        dm_we = (r_reg.bitc == tss_pkg::LAST_BIT);
      end else if (r_reg.bitc == tss_pkg::LAST_BIT) begin
        // cell boundary after the last bit: next channel
        r_next.bitc = tss_pkg::FIRST_BIT;
        r_next.slot = ld_slot;
        for (int l = 0; l < tss_pkg::LINES; l++) begin
          r_next.osh[l] = obyte[l];
        end
      end else begin
        r_next.bitc = r_reg.bitc + tss_pkg::BIT_W'(1);
        for (int l = 0; l < tss_pkg::LINES; l++) begin
          r_next.osh[l] = {r_reg.osh[l][tss_pkg::WORD_W-2:0], 1'b1};
        end
      end
    end

    // connection memory clear sweeps once per init frame
    if (r_reg.init && (r_reg.clr != tss_pkg::CM_LAST)) begin
      cm_we    = 1'b1;
      cm_waddr = r_reg.clr[tss_pkg::ADDR_W-1:0];
      cm_wdata = tss_pkg::CM_CLEAR;
      r_next.clr = r_reg.clr + tss_pkg::CM_W'(1);
    end else if (pop) begin
      if (!q_data[tss_pkg::ARG_W]) begin
        // data byte onto the argument stack
        r_next.stk = {r_reg.stk[2:0], q_data[tss_pkg::ARG_W-1:0]};
        if (r_reg.cnt != tss_pkg::ARGS_FOUR) begin
          r_next.cnt = r_reg.cnt + 3'h1;
        end
      end else begin
        // opcode byte: run it against the stacked arguments
        r_next.op  = q_data[2:0];
        r_next.cnt = '0;
        r_next.err = 1'b0;
        unique case (q_data[2:0])
          tss_pkg::OP_CONNECT: begin
            if (r_reg.cnt >= tss_pkg::ARGS_FOUR) begin
              cm_we = 1'b1;
              // cascade mismatch turns a connect into a disconnect
              if (q_data[tss_pkg::ARG_W+1]) begin
                cm_wdata = {tss_pkg::CM_POINTER,
                            mem_addr(r_reg.stk[3], r_reg.stk[2])};
              end
            end else begin
              r_next.err = 1'b1;
            end
          end
          tss_pkg::OP_DISCON: begin
            if (r_reg.cnt >= tss_pkg::ARGS_TWO) begin
              cm_we = q_data[tss_pkg::ARG_W+1];
            end else begin
              r_next.err = 1'b1;
            end
          end
          tss_pkg::OP_MESSAGE: begin
            if (r_reg.cnt >= tss_pkg::ARGS_FOUR) begin
              cm_we    = q_data[tss_pkg::ARG_W+1];
              cm_waddr = mem_addr(r_reg.stk[3], r_reg.stk[2]);
              cm_wdata = {tss_pkg::CM_MESSAGE, r_reg.stk[1][2:0],
                          r_reg.stk[0]};
            end else begin
              r_next.err = 1'b1;
            end
          end
          tss_pkg::OP_READ_CM: begin
            if (r_reg.cnt >= tss_pkg::ARGS_TWO) begin
              r_next.mrd = cm_mem[arg_addr][tss_pkg::WORD_W-1:0];
            end else begin
              r_next.err = 1'b1;
            end
          end
          tss_pkg::OP_READ_DM: begin
            if (r_reg.cnt >= tss_pkg::ARGS_TWO) begin
              r_next.mrd = dm_mem[arg_addr];
            end else begin
              r_next.err = 1'b1;
            end
          end
          default: begin
            // unknown code: flag it, touch nothing
            r_next.err = 1'b1;
          end
        endcase
      end
    end

    // read side, only when fully selected and not both strobes
    if (rd_fall && sel && matched && r_reg.s2.wr_n && !r_next.init) begin
      r_next.dout = r_reg.s2.cd
                    ? {r_reg.init, r_reg.err, ~q_in_ready,
                       tss_pkg::STATUS_PAD, r_reg.op}
                    : r_reg.mrd;
    end
    r_next.doe = ~r_reg.s2.rd_n & r_reg.s2.wr_n & sel & matched
                 & ~r_next.init;

    // open drain: enable only for a zero bit, never during init
    for (int l = 0; l < tss_pkg::LINES; l++) begin
      r_next.oe[l] = ~r_next.osh[l][tss_pkg::WORD_W-1]
                     & ~r_next.init;
    end
    r_next.lvl = '0;
    r_next.rdy = ~r_next.err;
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      r_reg     <= '0;
      r_reg.osh <= '1;
      r_reg.rdy <= 1'b1;
      // strobes and selects reset to their idle high level, so the
      // first clocks after reset see no false strobe edge
      r_reg.s1.wr_n    <= 1'b1;
      r_reg.s1.rd_n    <= 1'b1;
      r_reg.s1.sel_n   <= 2'b11;
      r_reg.s2.wr_n    <= 1'b1;
      r_reg.s2.rd_n    <= 1'b1;
      r_reg.s2.sel_n   <= 2'b11;
      r_reg.prev_wr_n  <= 1'b1;
      r_reg.prev_rd_n  <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // data memory: eight lines written together at byte end
  always_ff @(posedge SYS_CLK_I) begin
    if (dm_we) begin
      for (int l = 0; l < tss_pkg::LINES; l++) begin
        dm_mem[{tss_pkg::LINE_W'(l), r_reg.slot}] <= r_next.ish[l];
      end
    end
  end

  // connection memory: one write port shared by clear and commands
  always_ff @(posedge SYS_CLK_I) begin
    if (cm_we) begin
      cm_mem[cm_waddr] <= cm_wdata;
    end
  end

  // ************************************************************
  // outputs, all from flip-flops
  // ************************************************************
  assign SERIAL_OUT_LINE_O    = r_reg.lvl;
  assign SERIAL_OUT_LINE_OE_O = r_reg.oe;
  assign DATA_O               = r_reg.dout;
  assign DATA_OE_O            = r_reg.doe;
  assign READY_FLAG_OUT_O     = r_reg.rdy;

endmodule : tss_switch

// File: sim/tss_switch_props.sv
// Purpose: port-level checks for the pcm switch
// Assumes: one system clock, async active-high reset
// Notes:   pin effects land 3 or 4 clocks after the pin edge
`timescale 1ns/100ps
// ************************************************************
// checker
// ************************************************************
module tss_switch_props (
  // clock and reset
  input wire logic       SYS_CLK_I,
  input wire logic       RESET_I,
  // pins watched
  input wire logic       FRAME_SYNC_I,
  input wire logic       INIT_N_I,
  input wire logic [7:0] SERIAL_OUT_LINE_O,
  input wire logic [7:0] SERIAL_OUT_LINE_OE_O,
  input wire logic [7:0] DATA_O,
  input wire logic       DATA_OE_O,
  input wire logic       SELECT_N_FIRST_I,
  input wire logic       SELECT_N_SECOND_I,
  input wire logic       CASCADE_MATCH_A_I,
  input wire logic       CASCADE_MATCH_B_I,
  input wire logic       CASCADE_STRAP_A_I,
  input wire logic       CASCADE_STRAP_B_I,
  input wire logic       WR_N_I,
  input wire logic       RD_N_I,
  input wire logic       CMD_DATA_I,
  input wire logic       READY_FLAG_OUT_O
);
  logic       rd_sel;
  logic       wr_q;
  logic [3:0] op_age;
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);
  // fully decoded read strobe
  assign rd_sel = !RD_N_I && WR_N_I && !SELECT_N_FIRST_I
    && !SELECT_N_SECOND_I && (CASCADE_MATCH_A_I == CASCADE_STRAP_A_I)
    && (CASCADE_MATCH_B_I == CASCADE_STRAP_B_I);
  // age since an opcode strobe ended; saturates, so stale is safe
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      wr_q   <= 1'b1;
      op_age <= 4'hf;
    end else begin
      wr_q <= WR_N_I;
      if (WR_N_I && !wr_q && CMD_DATA_I) op_age <= 4'h0;
      else if (op_age != 4'hf) op_age <= op_age + 4'h1;
    end
  end
  sequence s_init_start;
    $rose(FRAME_SYNC_I) && !INIT_N_I;
  endsequence
  sequence s_quiet;
    (SERIAL_OUT_LINE_OE_O == 8'h00 && !DATA_OE_O) [*8];
  endsequence
  a_ser_level: assert property (SERIAL_OUT_LINE_O == 8'h00)
    else $error("serial output drives high");
  a_ready_reset: assert property ($fell(RESET_I) |-> READY_FLAG_OUT_O)
    else $error("ready low after reset");
  a_ready_cause: assert property ($fell(READY_FLAG_OUT_O) |-> op_age < 4'hc)
    else $error("ready fell without opcode");
  a_bus_float: assert property ((!WR_N_I && !RD_N_I) [*6] |-> !DATA_OE_O)
    else $error("bus driven with both strobes low");
  a_read_sel: assert property (DATA_OE_O |-> $past(rd_sel, 3) || $past(rd_sel, 4))
    else $error("bus driven without full select");
  a_data_change: assert property ($changed(DATA_O)
    |-> $past(!RD_N_I, 3) || $past(!RD_N_I, 4))
    else $error("read data moved without read strobe");
  a_oe_cell: assert property ($changed(SERIAL_OUT_LINE_OE_O)
    |=> $stable(SERIAL_OUT_LINE_OE_O) [*6])
    else $error("serial bit cell too short");
  a_init_quiet: assert property (s_init_start |-> ##6 s_quiet)
    else $error("drivers active during init");
endmodule : tss_switch_props
bind tss_switch tss_switch_props u_props (.SYS_CLK_I, .RESET_I,
  .FRAME_SYNC_I, .INIT_N_I, .SERIAL_OUT_LINE_O, .SERIAL_OUT_LINE_OE_O,
  .DATA_O, .DATA_OE_O, .SELECT_N_FIRST_I, .SELECT_N_SECOND_I,
  .CASCADE_MATCH_A_I, .CASCADE_MATCH_B_I, .CASCADE_STRAP_A_I,
  .CASCADE_STRAP_B_I, .WR_N_I, .RD_N_I, .CMD_DATA_I, .READY_FLAG_OUT_O);

// File: sim/tss_cpu_model.sv
// Purpose: controlling processor on the asynchronous byte bus
// Assumes: strobes held well over 4 system clocks
// Notes:   a released bus shows the inverse of the last byte
`timescale 1ns/100ps
// ************************************************************
// cpu model
// ************************************************************
module tss_cpu_model (
  // clock and bus view
  input  wire logic       clk_i,
  input  wire logic [7:0] data_i,
  input  wire logic       oe_i,
  // bus drive
  output logic [7:0]      bus_o,
  output logic [1:0]      sel_n_o,
  output logic            wr_n_o,
  output logic            rd_n_o,
  output logic            cd_o
);
  // idle bus at time zero
  initial begin
    bus_o   = 8'h00;
    sel_n_o = 2'b11;
    wr_n_o  = 1'b1;
    rd_n_o  = 1'b1;
    cd_o    = 1'b0;
  end
  // write byte; cd selects opcode or data
  task automatic wr(input logic c, input logic [7:0] d);
    @(posedge clk_i);
    bus_o   <= d;
    cd_o    <= c;
    sel_n_o <= 2'b00;
    wr_n_o  <= 1'b0;
    repeat (5) @(posedge clk_i);
    wr_n_o  <= 1'b1;
    repeat (5) @(posedge clk_i);
    sel_n_o <= 2'b11;
    bus_o   <= ~d;
  endtask : wr
  // read; b also lowers write, write lifts first so nothing queues
  task automatic rd(input logic c, b, output logic [7:0] q,
                    output logic oe);
    @(posedge clk_i);
    cd_o    <= c;
    sel_n_o <= 2'b00;
    rd_n_o  <= 1'b0;
    wr_n_o  <= ~b;
    repeat (6) @(posedge clk_i);
    q  = data_i;
    oe = oe_i;
    wr_n_o  <= 1'b1;
    repeat (5) @(posedge clk_i);
    rd_n_o  <= 1'b1;
    repeat (5) @(posedge clk_i);
    sel_n_o <= 2'b11;
  endtask : rd
endmodule : tss_cpu_model

// File: sim/tb.sv
// Purpose: self-checking bench for the pcm switch
// Assumes: master clock 16 system clocks, frame 8192 clocks
// Notes:   serial lines pulled up; input line 3 held low
`timescale 1ns/100ps
// ************************************************************
// bench top
// ************************************************************
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        init_n = 1'b1;
  logic        match_a = 1'b1;
  logic [12:0] tick = 13'h0000;
  logic [7:0]  cpu_bus, bus, pcm, q, out, out_oe, dat_o;
  logic [7:0]  cap [8];
  logic [1:0]  sel_n;
  logic        wr_n, rd_n, cd, oe, ready, dat_oe;
  int          mismatches = 0;
  int          checks = 0;
  // clock and frame timebase; sync rises at tick 0
  always #10 clk = ~clk;
  always @(posedge clk) tick <= tick + 13'h0001;
  // wires: dut wins the bus while enabled, pull-up on pcm
  assign bus = dat_oe ? dat_o : cpu_bus;
  assign pcm = (out_oe & out) | ~out_oe;
  tss_switch dut (.SYS_CLK_I(clk), .RESET_I(rst), .MCLK_I(tick[3]),
    .FRAME_SYNC_I(tick[12:4] == 9'h000), .INIT_N_I(init_n),
    .SERIAL_IN_LINE_I(8'hf7), .SERIAL_OUT_LINE_O(out),
    .SERIAL_OUT_LINE_OE_O(out_oe), .DATA_I(bus), .DATA_O(dat_o),
    .DATA_OE_O(dat_oe), .SELECT_N_FIRST_I(sel_n[0]),
    .SELECT_N_SECOND_I(sel_n[1]), .CASCADE_MATCH_A_I(match_a),
    .CASCADE_MATCH_B_I(1'b0), .CASCADE_STRAP_A_I(1'b1),
    .CASCADE_STRAP_B_I(1'b0), .WR_N_I(wr_n), .RD_N_I(rd_n),
    .CMD_DATA_I(cd), .READY_FLAG_OUT_O(ready));
  tss_cpu_model cpu (.clk_i(clk), .data_i(bus), .oe_i(dat_oe),
    .bus_o(cpu_bus), .sel_n_o(sel_n), .wr_n_o(wr_n), .rd_n_o(rd_n),
    .cd_o(cd));
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [7:0] got, exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // bounded wait, sampled on the falling edge where outputs settle
  task automatic wait_tick(input logic [12:0] t);
    int n;
    for (n = 0; n < 9000 && tick !== t; n++) @(negedge clk);
    if (n == 9000) begin
      mismatches++;
      print_verdict();
    end
  endtask : wait_tick
  // slot 0 byte of every line, msb first, mid cell
  task automatic grab();
    wait_tick(13'h0000);
    for (int b = 0; b < 8; b++) begin
      wait_tick(13'(16 + 32 * b));
      for (int l = 0; l < 8; l++) cap[l][7-b] = pcm[l];
    end
  endtask : grab
  task automatic t_init();
    wait_tick(13'h1000);
    @(posedge clk);
    init_n <= 1'b0;
    wait_tick(13'h0100);
    chk(out_oe, 8'h00);
    chk({7'h00, dat_oe}, 8'h00);
    @(posedge clk);
    init_n <= 1'b1;
  endtask : t_init
  // message on line 0 slot 0, line 3 slot 0 to line 1 slot 0
  task automatic t_ops();
    wait_tick(13'h0000);
    cpu.wr(1'b0, 8'he0);
    cpu.wr(1'b0, 8'he0);
    cpu.wr(1'b0, 8'he5);
    cpu.wr(1'b0, 8'he5);
    cpu.wr(1'b1, 8'(tss_pkg::OP_MESSAGE));
    cpu.wr(1'b0, 8'h03);
    cpu.wr(1'b0, 8'h00);
    cpu.wr(1'b0, 8'h01);
    cpu.wr(1'b0, 8'h00);
    cpu.wr(1'b1, 8'(tss_pkg::OP_CONNECT));
    grab();
    chk(cap[0], 8'ha5);
    chk(cap[1], 8'h00);
    chk(cap[3], 8'hff);
  endtask : t_ops
  // reset pin low only mid frame must not start init
  task automatic t_hold();
    wait_tick(13'h0800);
    @(posedge clk);
    init_n <= 1'b0;
    wait_tick(13'h0900);
    @(posedge clk);
    init_n <= 1'b1;
    grab();
    chk(cap[0], 8'ha5);
  endtask : t_hold
  task automatic t_status();
    cpu.wr(1'b1, 8'h07);
    repeat (12) @(negedge clk);
    chk({7'h00, ready}, 8'h00);
    cpu.rd(1'b1, 1'b0, q, oe);
    chk(q & 8'h40, 8'h40);
    match_a <= 1'b0;
    cpu.rd(1'b1, 1'b0, q, oe);
    chk({7'h00, oe}, 8'h00);
    match_a <= 1'b1;
    cpu.rd(1'b1, 1'b1, q, oe);
    chk({7'h00, oe}, 8'h00);
    cpu.wr(1'b0, 8'h00);
    cpu.wr(1'b0, 8'h00);
    cpu.wr(1'b1, 8'(tss_pkg::OP_READ_CM));
    repeat (12) @(negedge clk);
    chk({7'h00, ready}, 8'h01);
    cpu.rd(1'b0, 1'b0, q, oe);
    chk(q, 8'ha5);
    chk({7'h00, oe}, 8'h01);
  endtask : t_status
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({6'h00, ready, dat_oe}, 8'h02);
    t_init();
    t_ops();
    t_hold();
    t_status();
    print_verdict();
  end
endmodule : tb
